// [rdcp_host_model.sv]
// Remote host model that sends command lines as ASCII characters.
`timescale 1ns/1ns
module rdcp_host_model
	import rdcp_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Command character stream.
	input wire logic cmd_ready,
	output logic cmd_valid,
	output logic [7:0] cmd_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_data = 8'h00;
	end

	// ****************************************
	// Line sender
	// ****************************************
	// Sends one line and its terminator, then waits until the parser is idle again.
	// A legacy line is cut to twelve characters unless an overlong line is wanted.
	task automatic send_line(input string s, input bit over = 1'b0);
		string t;
		bit leg;
		t = s;
		leg = ((t[0] & CASE_FOLD) == CH_A) || ((t[0] & CASE_FOLD) == CH_B);
		if (leg && !over && t.len() > 12) begin
			t = t.substr(0, 11);
		end
		for (int i = 0; i <= t.len(); i++) begin
			@(negedge clk);
			while (cmd_ready !== 1'b1) @(negedge clk);
			@(posedge clk);
			cmd_valid <= 1'b1;
			cmd_data <= (i == t.len()) ? CH_LF : t[i];
		end
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		while (cmd_ready !== 1'b1) @(negedge clk);
	endtask
endmodule

// [rdcp_pkg.sv]
// Constants and types shared by the relay driver command parser.
package rdcp_pkg;

	// Channel layout.
	localparam int CHN = 20;
	localparam int BANK_CH = 10;
	localparam logic [4:0] BANK_OFS = 5'h0a;
	localparam logic [4:0] GRP_OFS = 5'h04;
	localparam logic [9:0] BANK_BASE = 10'h064;
	localparam logic [9:0] CH_B1_LO = 10'h065;
	localparam logic [9:0] CH_B1_HI = 10'h06e;
	localparam logic [9:0] CH_B2_LO = 10'h0c9;
	localparam logic [9:0] CH_B2_HI = 10'h0d2;
	localparam logic [3:0] BANK_ONE = 4'h1;
	localparam logic [3:0] BANK_TWO = 4'h2;
	localparam logic [CHN-1:0] CHAN_RST = 20'hfffff;

	// Characters of the command stream.
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_LPAR = 8'h28;
	localparam logic [7:0] CH_RPAR = 8'h29;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_AT = 8'h40;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_B = 8'h42;
	localparam logic [7:0] CH_X = 8'h58;
	localparam logic [7:0] CH_Y = 8'h59;
	localparam logic [7:0] CASE_FOLD = 8'hdf;

	// Structured command codes, one leading character each.
	localparam logic [7:0] OP_LEG = 8'h41;
	localparam logic [7:0] OP_CLOSE = 8'h43;
	localparam logic [7:0] OP_OPEN = 8'h4f;
	localparam logic [7:0] OP_CLOSE_ALL = 8'h4b;
	localparam logic [7:0] OP_OPEN_ALL = 8'h4c;
	localparam logic [7:0] OP_Q_CLOSED = 8'h51;
	localparam logic [7:0] OP_Q_OPEN = 8'h52;
	localparam logic [7:0] OP_CNT_Q = 8'h4e;
	localparam logic [7:0] OP_CNT_CLR = 8'h5a;
	localparam logic [7:0] OP_CNT_CLR_ALL = 8'h57;
	localparam logic [7:0] OP_SUP_SET = 8'h53;
	localparam logic [7:0] OP_SUP_Q = 8'h73;
	localparam logic [7:0] OP_TTL_SET = 8'h54;
	localparam logic [7:0] OP_TTL_Q = 8'h74;
	localparam logic [7:0] OP_MODEL_SET = 8'h4d;
	localparam logic [7:0] OP_LVL_SET = 8'h56;
	localparam logic [7:0] OP_LVL_Q = 8'h76;

	// Register port map and fields.
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_LADDR = 2'h1;
	localparam logic [1:0] REG_STAT = 2'h2;
	localparam logic [1:0] REG_CHAN = 2'h3;
	localparam int CTRL_REMOTE = 0;
	localparam int CTRL_LISTEN = 1;
	localparam int CTRL_ONEBANK = 2;
	localparam int STAT_ERR = 0;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [4:0] LADDR_RST = 5'h1c;
	localparam logic [4:0] LADDR_MAX = 5'h1e;

	// Settings.
	localparam logic [2:0] SUP_OFF = 3'h0;
	localparam logic [2:0] SUP_USER = 3'h4;
	localparam logic [2:0] SUP_RST = 3'h3;
	localparam logic [3:0] MODEL_NONE = 4'h0;
	localparam logic [3:0] MODEL_MAX = 4'ha;
	localparam logic [3:0] LEG_MAX_LEN = 4'hc;
	localparam logic [7:0] SEC_DB [4] = '{8'h0a, 8'h14, 8'h28, 8'h28};

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARGS = 2'b01,
		ST_EXEC = 2'b11,
		ST_RESP = 2'b10
	} rdcp_state_t;

endpackage

// [rdcp_relay_parser.sv]
// Command interpreter of a two-bank attenuator and switch relay driver.
// Summary of operation
// - A channel is written (@bnn): first digit bank, last two the channel.
// - Channels 101..110 and 201..210 are valid.
// - With the single-bank option every bank digit counts as bank one.
// - Invalid channels inside a range are skipped; endpoints must be valid.
// - Close or open listed channels, or all channels at once.
// - State queries answer 1 where the asked condition holds, else 0.
// - Each bank keeps one supply choice and reports it on query.
// - Each bank keeps a TTL on/off setting; query answers 1 or 0.
// - Every channel has a relay actuation count, reported on query.
// - Counts clear for listed channels or for all channels.
// - Attenuator model kept per bank and position, including none.
// - With equal sections, section four engages before section three.
// - Set total attenuation of a position; query reports it.
// - Legacy on-letter turns named channels on, off-letter turns them off.
// - Legacy strings act only while remote and addressed to listen.
// - Legacy letters are accepted in either case.
// - Legacy digits 1-4 drive the first group, 5-8 the second.
// - Legacy digit nine drives switch nine, digit zero switch ten.
// - Legacy strings reach bank one only.
// - A channel on means attenuation applied or path closed.
// - Listener address 0..30 survives interface reset.
`timescale 1ns/1ns
module rdcp_relay_parser
	import rdcp_pkg::*;
(
	// Clock, resets and clock enable.
	input wire logic clk,
	input wire logic reset_n,
	input wire logic por_n,
	input wire logic ce,
	// Command character stream.
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	// Query answers.
	output logic resp_valid,
	output logic [15:0] resp_data,
	output logic resp_last,
	// Register port.
	input wire logic [1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Relay and bank drive.
	output logic [CHN-1:0] chan_on,
	output logic [5:0] supply_sel,
	output logic [1:0] ttl_on,
	output logic [4:0] listen_addr
);

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	function automatic logic [9:0] norm(input logic [9:0] n, input logic one);
		norm = one ? BANK_BASE + 10'(n % 10'd100) : n;
	endfunction

	function automatic logic chan_ok(input logic [9:0] n);
		chan_ok = (n >= CH_B1_LO && n <= CH_B1_HI) || (n >= CH_B2_LO && n <= CH_B2_HI);
	endfunction

	// Greedy pick from the largest section down, so section four wins a tie.
	function automatic logic [3:0] sec_pick(input logic [9:0] db);
		logic [9:0] rem;
		rem = db;
		sec_pick = 4'h0;
		for (int k = 3; k >= 0; k--) begin
			if (rem >= 10'(SEC_DB[k])) begin
				sec_pick[k] = 1'b1;
				rem = rem - 10'(SEC_DB[k]);
			end
		end
	endfunction

	function automatic logic [9:0] sec_total(input logic [3:0] sec);
		sec_total = 10'h000;
		for (int k = 0; k < 4; k++) begin
			if (sec[k]) begin
				sec_total = sec_total + 10'(SEC_DB[k]);
			end
		end
	endfunction

	rdcp_state_t state_reg, state_next;
	logic [7:0] op_reg;
	logic leg_reg, pol_reg, err_reg, rng_reg, hasb_reg, pos_reg, op_ok;
	logic [9:0] num_reg, lo_reg, lon_reg, loff_reg;
	logic [3:0] bank_reg, len_reg;
	logic [4:0] ridx_reg;
	logic [CHN-1:0] mask_reg, chan_reg, ch_next;
	logic [2:0] ctrl_reg;
	logic [4:0] laddr_reg;
	logic serr_reg, rv_reg, rl_reg;
	logic [15:0] rd_reg, resp_sel;
	logic [31:0] rdata_reg;
	logic [2:0] sup_reg [2];
	logic [1:0] ttl_reg;
	logic [3:0] model_reg [4];
	logic [9:0] att_reg [4];
	logic [15:0] cnt_reg [CHN];

	// ****************************************************************
	// Character decode.
	// ****************************************************************
	wire take = ce && cmd_valid && cmd_ready;
	wire [7:0] up = cmd_data & CASE_FOLD;
	wire is_dig = cmd_data >= CH_0 && cmd_data <= CH_9;
	wire [3:0] dval = 4'(cmd_data - CH_0);
	wire is_end = cmd_data == CH_LF;
	wire is_leg = up == CH_A || up == CH_B;
	wire op_list = op_reg inside {OP_CLOSE, OP_OPEN, OP_Q_CLOSED, OP_Q_OPEN, OP_CNT_Q, OP_CNT_CLR};
	wire op_list_c = cmd_data inside {OP_CLOSE, OP_OPEN, OP_CLOSE_ALL, OP_OPEN_ALL, OP_Q_CLOSED, OP_Q_OPEN,
		OP_CNT_Q, OP_CNT_CLR, OP_CNT_CLR_ALL, OP_SUP_SET, OP_SUP_Q, OP_TTL_SET, OP_TTL_Q, OP_MODEL_SET,
		OP_LVL_SET, OP_LVL_Q};
	wire op_known = is_leg || op_list_c;
	wire op_single_q = op_reg inside {OP_SUP_Q, OP_TTL_Q, OP_LVL_Q};
	wire op_query = op_single_q || op_reg inside {OP_Q_CLOSED, OP_Q_OPEN, OP_CNT_Q};
	wire one_bank = ctrl_reg[CTRL_ONEBANK];
	wire [9:0] num_n = norm(num_reg, one_bank);
	wire [9:0] lo_n = norm(lo_reg, one_bank);
	wire [3:0] bank_eff = one_bank ? BANK_ONE : bank_reg;
	wire bank_ok = bank_eff == BANK_ONE || bank_eff == BANK_TWO;
	wire bi = bank_eff == BANK_TWO;
	wire [1:0] slot = {bi, pos_reg};
	wire [3:0] sec = sec_pick(num_reg);
	wire [9:0] sec_sum = sec_total(sec);
	wire [4:0] base = (bi ? BANK_OFS : 5'h00) + (pos_reg ? GRP_OFS : 5'h00);
	wire [CHN-1:0] sec_vec = CHN'(sec) << base;
	wire [CHN-1:0] sec_msk = CHN'(4'hf) << base;
	wire item_end = cmd_data == CH_COMMA || cmd_data == CH_RPAR;
	wire leg_act = ctrl_reg[CTRL_REMOTE] && ctrl_reg[CTRL_LISTEN];
	wire exec = ce && state_reg == ST_EXEC;
	wire commit = exec && !err_reg && op_ok;
	wire cnt_all = commit && op_reg == OP_CNT_CLR_ALL;
	wire [CHN-1:0] clr = cnt_all ? {CHN{1'b1}} : (commit && op_reg == OP_CNT_CLR) ? mask_reg : '0;
	wire [CHN-1:0] tog = ch_next ^ chan_reg;
	wire resp_hit = mask_reg[ridx_reg];
	wire resp_end = resp_hit && !(|(mask_reg >> (ridx_reg + 5'd1)));
	wire [CHN-1:0] rng_hit, one_hit, lset, lclr;

	assign cmd_ready = state_reg == ST_IDLE || state_reg == ST_ARGS;

	// ****************************************************************
	// Per-channel decode and relay actuation counters.
	// ****************************************************************
	for (genvar i = 0; i < CHN; i++) begin : g_ch
		localparam logic [9:0] CNUM = i < BANK_CH ? CH_B1_LO + 10'(i) : CH_B2_LO + 10'(i - BANK_CH);
		localparam int DIG = (i == BANK_CH - 1) ? 0 : i + 1;
		assign rng_hit[i] = CNUM >= lo_n && CNUM <= num_n;
		assign one_hit[i] = CNUM == num_n;
		if (i < BANK_CH) begin : g_leg
			assign lset[i] = lon_reg[DIG];
			assign lclr[i] = loff_reg[DIG];
		end else begin : g_noleg
			assign lset[i] = 1'b0;
			assign lclr[i] = 1'b0;
		end
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				cnt_reg[i] <= 16'h0000;
			end else if (ce && clr[i]) begin
				cnt_reg[i] <= 16'h0000;
			end else if (ce && tog[i]) begin
				cnt_reg[i] <= cnt_reg[i] + 16'h0001;
			end
		end
	end

	// ****************************************************************
	// Parser and command execution.
	// ****************************************************************
	always_comb begin
		case (op_reg)
			OP_SUP_SET: op_ok = bank_ok && hasb_reg && num_reg <= 10'(SUP_USER);
			OP_TTL_SET: op_ok = bank_ok && hasb_reg && num_reg <= 10'h001;
			OP_MODEL_SET: op_ok = bank_ok && hasb_reg && num_reg <= 10'(MODEL_MAX);
			OP_LVL_SET: op_ok = bank_ok && hasb_reg && model_reg[slot] != MODEL_NONE;
			OP_SUP_Q, OP_TTL_Q, OP_LVL_Q: op_ok = bank_ok && hasb_reg;
			default: op_ok = 1'b1;
		endcase
	end

	always_comb begin
		ch_next = chan_reg;
		if (commit) begin
			case (op_reg)
				OP_CLOSE: ch_next = chan_reg | mask_reg;
				OP_OPEN: ch_next = chan_reg & ~mask_reg;
				OP_CLOSE_ALL: ch_next = {CHN{1'b1}};
				OP_OPEN_ALL: ch_next = '0;
				OP_LVL_SET: ch_next = (chan_reg & ~sec_msk) | sec_vec;
				OP_LEG: ch_next = leg_act ? ((chan_reg & ~lclr) | lset) : chan_reg;
				default: ch_next = chan_reg;
			endcase
		end
	end

	always_comb begin
		case (state_reg)
			ST_IDLE: state_next = (take && !is_end) ? ST_ARGS : ST_IDLE;
			ST_ARGS: state_next = (take && is_end) ? ST_EXEC : ST_ARGS;
			ST_EXEC: state_next = (commit && op_query) ? ST_RESP : ST_IDLE;
			ST_RESP: state_next = (resp_end || ridx_reg == 5'(CHN - 1)) ? ST_IDLE : ST_RESP;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			op_reg <= 8'h00;
			{leg_reg, pol_reg, err_reg, rng_reg, hasb_reg, pos_reg} <= 6'h00;
			{num_reg, lo_reg, lon_reg, loff_reg} <= 40'h0;
			bank_reg <= 4'h0;
			len_reg <= 4'h0;
			mask_reg <= '0;
			ridx_reg <= 5'h00;
		end else if (ce) begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE && take && !is_end) begin
				op_reg <= is_leg ? OP_LEG : cmd_data;
				leg_reg <= is_leg;
				pol_reg <= up == CH_A;
				err_reg <= !op_known;
				{rng_reg, hasb_reg, pos_reg} <= 3'h0;
				{num_reg, lo_reg, lon_reg, loff_reg} <= 40'h0;
				bank_reg <= 4'h0;
				len_reg <= 4'h1;
				mask_reg <= '0;
			end else if (state_reg == ST_ARGS && take && !is_end) begin
				if (len_reg != 4'hf) begin
					len_reg <= len_reg + 4'h1;
				end
				if (leg_reg) begin
					if (len_reg >= LEG_MAX_LEN) begin
						err_reg <= 1'b1;
					end
					if (is_leg) begin
						pol_reg <= up == CH_A;
					end else if (is_dig && pol_reg) begin
						lon_reg[dval] <= 1'b1;
					end else if (is_dig) begin
						loff_reg[dval] <= 1'b1;
					end else begin
						err_reg <= 1'b1;
					end
				end else if (is_dig && !op_list && !hasb_reg) begin
					bank_reg <= dval;
					hasb_reg <= 1'b1;
				end else if (is_dig) begin
					if (num_reg >= 10'h064) begin
						err_reg <= 1'b1;
					end else begin
						num_reg <= 10'(num_reg * 10'd10 + 10'(dval));
					end
				end else if (!op_list && (up == CH_X || up == CH_Y)) begin
					pos_reg <= up == CH_Y;
				end else if (op_list && cmd_data == CH_COLON) begin
					lo_reg <= num_reg;
					rng_reg <= 1'b1;
					num_reg <= 10'h000;
				end else if (op_list && item_end) begin
					num_reg <= 10'h000;
					rng_reg <= 1'b0;
					if (rng_reg && chan_ok(lo_n) && chan_ok(num_n)) begin
						mask_reg <= mask_reg | rng_hit;
					end else if (!rng_reg && chan_ok(num_n)) begin
						mask_reg <= mask_reg | one_hit;
					end else begin
						err_reg <= 1'b1;
					end
				end else if (!(cmd_data inside {CH_SP, CH_CR, CH_LPAR, CH_AT})) begin
					err_reg <= 1'b1;
				end
			end else if (state_reg == ST_EXEC) begin
				ridx_reg <= 5'h00;
				if (op_single_q) begin
					mask_reg <= CHN'(1'b1);
				end
			end else if (state_reg == ST_RESP) begin
				ridx_reg <= ridx_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_reg <= CHAN_RST;
		end else if (ce) begin
			chan_reg <= ch_next;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sup_reg <= '{SUP_RST, SUP_RST};
			ttl_reg <= 2'h0;
			model_reg <= '{MODEL_NONE, MODEL_NONE, MODEL_NONE, MODEL_NONE};
			att_reg <= '{10'h000, 10'h000, 10'h000, 10'h000};
		end else if (commit) begin
			case (op_reg)
				OP_SUP_SET: sup_reg[bi] <= num_reg[2:0];
				OP_TTL_SET: ttl_reg[bi] <= num_reg[0];
				OP_MODEL_SET: model_reg[slot] <= num_reg[3:0];
				OP_LVL_SET: att_reg[slot] <= sec_sum;
				default: ttl_reg <= ttl_reg;
			endcase
		end
	end

	// ****************************************************************
	// Query answers and register port.
	// ****************************************************************
	always_comb begin
		case (op_reg)
			OP_Q_CLOSED: resp_sel = 16'(chan_reg[ridx_reg]);
			OP_Q_OPEN: resp_sel = 16'(!chan_reg[ridx_reg]);
			OP_CNT_Q: resp_sel = cnt_reg[ridx_reg];
			OP_SUP_Q: resp_sel = 16'(sup_reg[bi]);
			OP_TTL_Q: resp_sel = 16'(ttl_reg[bi]);
			OP_LVL_Q: resp_sel = 16'(att_reg[slot]);
			default: resp_sel = 16'h0000;
		endcase
	end

	wire resp_go = ce && state_reg == ST_RESP && resp_hit;
	wire wr_ctrl = ce && reg_wr && reg_addr == REG_CTRL;
	wire wr_laddr = ce && reg_wr && reg_addr == REG_LADDR && reg_wdata[31:0] <= 32'(LADDR_MAX);
	wire clr_err = ce && reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_ERR];
	wire set_err = exec && !commit;
	wire [31:0] rsel = reg_addr == REG_CTRL ? 32'(ctrl_reg) :
		reg_addr == REG_LADDR ? 32'(laddr_reg) :
		reg_addr == REG_STAT ? 32'({state_reg != ST_IDLE, serr_reg}) : 32'(chan_reg);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{rv_reg, rl_reg} <= 2'h0;
			rd_reg <= 16'h0000;
			ctrl_reg <= CTRL_RST;
			serr_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else if (ce) begin
			rv_reg <= resp_go;
			rl_reg <= resp_go && resp_end;
			rd_reg <= resp_go ? resp_sel : 16'h0000;
			if (wr_ctrl) begin
				ctrl_reg <= reg_wdata[2:0];
			end
			serr_reg <= set_err || (serr_reg && !clr_err);
			rdata_reg <= reg_rd ? rsel : 32'h00000000;
		end
	end

	// Listener address only follows power-on reset, never the interface reset.
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			laddr_reg <= LADDR_RST;
		end else if (wr_laddr) begin
			laddr_reg <= reg_wdata[4:0];
		end
	end

	assign resp_valid = rv_reg;
	assign resp_data = rd_reg;
	assign resp_last = rl_reg;
	assign reg_rdata = rdata_reg;
	assign chan_on = chan_reg;
	assign supply_sel = {sup_reg[1], sup_reg[0]};
	assign ttl_on = ttl_reg;
	assign listen_addr = laddr_reg;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_close_list: assert property (commit && op_reg == OP_CLOSE |=> (chan_reg & $past(mask_reg)) == $past(mask_reg))
		else $error("listed channels not switched on");
	a_open_all: assert property (commit && op_reg == OP_OPEN_ALL |=> chan_reg == '0)
		else $error("open all left a channel on");
	a_bad_keeps: assert property (exec && !commit |=> $stable(chan_reg) && $stable(ttl_reg))
		else $error("malformed command changed state");
	a_leg_gate: assert property (exec && op_reg == OP_LEG && !leg_act |=> $stable(chan_reg))
		else $error("legacy string acted while not listening");
	a_leg_bank: assert property (exec && op_reg == OP_LEG |=> chan_reg[19:10] == $past(chan_reg[19:10]))
		else $error("legacy string reached bank two");
	a_cnt_clear: assert property (cnt_all |=> cnt_reg[0] == 16'h0000 && cnt_reg[19] == 16'h0000)
		else $error("clear all left a count");
	a_cnt_step: assert property (ce && tog[0] && !clr[0] |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
		else $error("relay count did not step");
	a_sec_order: assert property (exec && op_reg == OP_LVL_SET |-> !(sec[2] && !sec[3]))
		else $error("section three engaged before four");
	a_lvl_store: assert property (commit && op_reg == OP_LVL_SET |=> att_reg[slot] == $past(sec_sum))
		else $error("attenuation value not stored");
	a_sup_store: assert property (commit && op_reg == OP_SUP_SET |=> sup_reg[bi] == $past(num_reg[2:0]))
		else $error("supply choice not stored");
	a_laddr_range: assert property (listen_addr <= LADDR_MAX)
		else $error("listener address above limit");

endmodule

// [tb_top.sv]
// Self-checking testbench of the relay driver command parser.
`timescale 1ns/1ns
module tb_top;
	import rdcp_pkg::*;

	logic clk, reset_n, por_n, ce, cmd_valid, cmd_ready, resp_valid, resp_last, reg_wr, reg_rd;
	logic [7:0] cmd_data;
	logic [15:0] resp_data;
	logic [1:0] reg_addr, ttl_on;
	logic [31:0] reg_wdata, reg_rdata, chan32;
	logic [CHN-1:0] chan_on;
	logic [5:0] supply_sel;
	logic [4:0] listen_addr;
	logic [15:0] rq[$];
	bit got_last;
	int errors = 0;
	int compares = 0;

	assign chan32 = {12'h000, chan_on};

	rdcp_relay_parser u_dut (.clk(clk), .reset_n(reset_n), .por_n(por_n), .ce(ce), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
		.resp_last(resp_last), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .chan_on(chan_on), .supply_sel(supply_sel), .ttl_on(ttl_on),
		.listen_addr(listen_addr));
	rdcp_host_model u_host (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_data(cmd_data));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		if (resp_valid === 1'b1) begin
			rq.push_back(resp_data);
			if (resp_last === 1'b1) got_last = 1'b1;
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	// Answer items are packed sixteen bits each, the first in the low bits.
	task automatic ask(input string s, input int n, input logic [63:0] e);
		int w;
		rq.delete();
		got_last = 1'b0;
		u_host.send_line(s);
		w = 0;
		while (!got_last && w < 100) begin
			@(negedge clk);
			w++;
		end
		chk("answer last", {31'h0, got_last}, 32'h1);
		chk("answer count", 32'(rq.size()), 32'(n));
		for (int k = 0; k < n && k < rq.size(); k++) chk("answer item", {16'h0000, rq[k]}, {16'h0000, e[16*k +: 16]});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_route;
		logic [31:0] d;
		chk("chan", chan32, 32'hfffff);
		chk("supply", {26'h0, supply_sel}, 32'h1b);
		u_host.send_line("L");
		chk("chan", chan32, 32'h0);
		u_host.send_line("C(@104,107,201,206)");
		chk("chan", chan32, 32'h08448);
		u_host.send_line("C(@108:203)");
		chk("chan", chan32, 32'h09fc8);
		u_host.send_line("O(@100:105)");
		chk("chan", chan32, 32'h09fc8);
		reg_read(REG_STAT, d);
		chk("error flag", {31'h0, d[STAT_ERR]}, 32'h1);
		reg_write(REG_STAT, 32'h1);
		reg_read(REG_STAT, d);
		chk("error flag", {31'h0, d[STAT_ERR]}, 32'h0);
		u_host.send_line("O(@104)");
		reg_read(REG_CHAN, d);
		chk("chan register", d, 32'h09fc0);
		u_host.send_line("K");
		chk("chan", chan32, 32'hfffff);
	endtask

	task automatic t_query;
		u_host.send_line("L");
		u_host.send_line("C(@102)");
		ask("Q(@101:103)", 3, 64'h0000_0000_0001_0000);
		ask("R(@101:103)", 3, 64'h0000_0001_0000_0001);
	endtask

	task automatic t_settings;
		for (int v = 0; v < 5; v++) begin
			u_host.send_line($sformatf("S1%0d", v));
			chk("supply", {29'h0, supply_sel[2:0]}, 32'(v));
			ask("s1", 1, 64'(v));
		end
		u_host.send_line("S22");
		chk("supply", {29'h0, supply_sel[5:3]}, 32'h2);
		u_host.send_line("T21");
		chk("ttl", {30'h0, ttl_on}, 32'h2);
		ask("t2", 1, 64'h1);
		u_host.send_line("T20");
		ask("t2", 1, 64'h0);
	endtask

	task automatic t_counts;
		u_host.send_line("K");
		u_host.send_line("W");
		u_host.send_line("L");
		u_host.send_line("K");
		ask("N(@101,210)", 2, 64'h0000_0000_0002_0002);
		u_host.send_line("Z(@101)");
		ask("N(@101,210)", 2, 64'h0000_0000_0002_0000);
		u_host.send_line("W");
		ask("N(@101,210)", 2, 64'h0);
	endtask

	task automatic t_atten;
		u_host.send_line("L");
		u_host.send_line("V1X30");
		chk("chan", chan32, 32'h0);
		u_host.send_line("M1X1");
		u_host.send_line("V1X50");
		chk("chan", chan32, 32'h9);
		u_host.send_line("V1X40");
		chk("chan", chan32, 32'h8);
		u_host.send_line("V1X80");
		chk("chan", chan32, 32'hc);
		ask("v1X", 1, 64'h50);
		u_host.send_line("M1Y2");
		u_host.send_line("V1Y30");
		chk("chan", chan32, 32'h3c);
	endtask

	task automatic t_legacy;
		logic [31:0] d;
		u_host.send_line("L");
		u_host.send_line("A1");
		chk("chan", chan32, 32'h0);
		reg_write(REG_CTRL, 32'h1);
		u_host.send_line("A1");
		chk("chan", chan32, 32'h0);
		reg_write(REG_CTRL, 32'h3);
		reg_read(REG_CTRL, d);
		chk("ctrl register", d, 32'h3);
		u_host.send_line("A1290");
		chk("chan", chan32, 32'h303);
		u_host.send_line("b9a5");
		chk("chan", chan32, 32'h213);
		u_host.send_line("K");
		u_host.send_line("B1234567890");
		chk("chan", chan32, 32'hffc00);
		u_host.send_line("a123456789012", 1'b1);
		chk("chan", chan32, 32'hffc00);
		reg_write(REG_CTRL, 32'h7);
		u_host.send_line("K");
		u_host.send_line("O(@205)");
		chk("chan", chan32, 32'hfffef);
		reg_write(REG_CTRL, 32'h0);
	endtask

	task automatic t_laddr;
		logic [31:0] d;
		chk("listen address", {27'h0, listen_addr}, 32'h1c);
		reg_write(REG_LADDR, 32'h1f);
		@(negedge clk);
		chk("listen address", {27'h0, listen_addr}, 32'h1c);
		reg_write(REG_LADDR, 32'h1e);
		ce <= 1'b0;
		reg_write(REG_LADDR, 32'h05);
		ce <= 1'b1;
		@(negedge clk);
		chk("listen address", {27'h0, listen_addr}, 32'h1e);
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		reset_n <= 1'b1;
		reg_read(REG_LADDR, d);
		chk("listen address", d, 32'h1e);
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		reset_n = 1'b0;
		por_n = 1'b0;
		ce = 1'b1;
		reg_addr = 2'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		por_n <= 1'b1;
		t_route();
		t_query();
		t_settings();
		t_counts();
		t_atten();
		t_legacy();
		t_laddr();
		end_of_test();
	end

	initial begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule
